// [design/cplps_ctrl.sv]
// cpu low-power state controller with operating-point and thermal sequencing
// Summary of operation
// RULE1: idle instruction enters idle powerdown; smi, init, local or bus irq wakes.
// RULE2: stop-clock asserted then released in idle powerdown resumes idle powerdown.
// RULE3: stop-clock issues acknowledge cycle; stop-grant 20 clocks after its response.
// RULE4: system leaves bus pins undriven and inputs inactive during stop-grant.
// RULE5: reset in stop-grant reinitialises but stays; stop-clock release returns Normal.
// RULE6: reset in idle powerdown starts initialisation at once.
// RULE7: system releases stop-clock at least ten clocks after releasing sleep.
// RULE8: snoop or irq in stop-grant or idle enters snoop-service, then returns. An irq in idle wakes straight to Normal instead.
// RULE9: stop-grant latches events, serviced once each after returning to Normal.
// RULE10: pending-break asserted in stop-grant when any irq is latched, mask ignored.
// RULE11: system answers pending-break by releasing stop-clock.
// RULE12: sleep entered only from stop-grant on sleep request; context kept.
// RULE13: system asserts sleep request only while device is in stop-grant.
// RULE14: system keeps bus quiet in sleep except sleep, deep-sleep, reset.
// RULE15: sleep states neither answer snoops nor latch interrupts.
// RULE16: reset in sleep resets directly, skipping stop-grant; system drops requests.
// RULE17: deep-sleep request in sleep enters deep sleep; release walks back up.
// RULE18: platform stops bus clock with deep-sleep and restarts it on exit.
// RULE19: 30 us relock after deep-sleep release before counting as sleep.
// RULE20: upward change drives voltage code first; downward relocks first.
// RULE21: software change accepted anytime, deferred while a transition runs.
// RULE22: bus-not-ready blocks snoops for the 10 us relock.
// RULE23: overheat moves to programmed low point, waits, returns when cooled.
// RULE24: interrupt raised on every thermal down and up transition.
// RULE25: power-status asserted in deep or deeper sleep, released on exit.
// RULE26: stop-clock, sleep and deep-sleep requests synchronised before use.
// RULE27: current low-power state exposed as an encoded status output.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cplps_ctrl #(
  parameter int THERM_WAIT = cplps_pkg::THERM_WAIT_CYC
) (
  input wire logic sys_clk_i, // bus clock
  input wire logic resetn_i, // async reset, active low
  input wire logic cpu_reset_n_i, // device reset pin, active low
  input wire logic stop_clock_req_n_i, // stop-clock request
  input wire logic sleep_req_n_i, // sleep request
  input wire logic deep_sleep_req_n_i, // deep-sleep request
  input wire logic deeper_volt_i, // platform lowered core voltage
  input wire logic halt_exec_i, // idle instruction executed
  input wire logic sys_mgmt_irq_n_i, // system-management interrupt
  input wire logic init_req_n_i, // init request
  input wire logic [1:0] local_irq_lines_i, // local interrupt lines
  input wire logic bus_irq_msg_i, // interrupt message on bus
  input wire logic snoop_req_i, // snoop seen on bus
  input wire logic snoop_done_i, // snoop serviced by any agent
  input wire logic ack_resp_done_i, // acknowledge cycle response done
  input wire logic thermal_hot_i, // die too hot
  input wire logic [cplps_pkg::ADDR_W-1:0] reg_addr_i, // register address
  input wire logic [31:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [31:0] reg_rdata_o, // read data, cycle after strobe
  output logic ack_cycle_o, // issue acknowledge special cycle
  output logic core_init_o, // start core initialisation
  output logic [cplps_pkg::EVT_W-1:0] evt_service_o, // latched events to service
  output logic pending_break_n_o, // pending interrupt in stop-grant
  output logic power_status_n_o, // deep or deeper sleep
  output logic bus_not_ready_n_o, // block snoops
  output logic [cplps_pkg::VID_W-1:0] voltage_id_code_o, // voltage code
  output logic [cplps_pkg::RATIO_W-1:0] core_ratio_o, // loop ratio
  output logic thermal_irq_o, // thermal transition interrupt
  output logic [3:0] lp_state_o // encoded low-power state
);
  import cplps_pkg::*;

  typedef struct packed {
    logic stop_m;
    logic stop_s;
    logic slp_m;
    logic slp_s;
    logic dps_m;
    logic dps_s;
    cplps_lp_t st;
    logic halted;
    logic snoop_ret_idle;
    logic snoop_irq;
    logic [TMR_W-1:0] cnt;
    logic [EVT_W-1:0] pend;
    logic [EVT_W-1:0] svc;
    logic ack_cycle;
    logic core_init;
    logic pbe_n;
    logic psi_n;
    cplps_op_t op;
    logic op_up;
    logic sw_pend;
    logic [VID_W-1:0] tgt_vid;
    logic [VID_W-1:0] cur_vid;
    logic [VID_W-1:0] th_vid;
    logic [VID_W-1:0] prev_vid;
    logic [VID_W-1:0] mv_vid;
    logic [RATIO_W-1:0] tgt_ratio;
    logic [RATIO_W-1:0] cur_ratio;
    logic [RATIO_W-1:0] th_ratio;
    logic [RATIO_W-1:0] prev_ratio;
    logic [RATIO_W-1:0] mv_ratio;
    logic [TMR_W-1:0] op_cnt;
    logic throttled;
    logic th_waiting;
    logic [THW_W-1:0] th_cnt;
    logic th_irq;
    logic bnr_n;
    logic [31:0] rdata;
  } cplps_state_t;

  cplps_state_t r;
  cplps_state_t n;

  logic core_rst;
  logic [EVT_W-1:0] ev;
  assign core_rst = !cpu_reset_n_i;
  assign ev = {bus_irq_msg_i, local_irq_lines_i, !init_req_n_i, !sys_mgmt_irq_n_i};

  // leaving stop-grant: back to idle powerdown unless events wait for service
  function automatic logic go_idle(input cplps_state_t s, input logic [EVT_W-1:0] p);
    go_idle = s.halted && (p == '0);
  endfunction : go_idle

  always_comb
  begin
    logic [EVT_W-1:0] pl;
    logic go;
    logic [VID_W-1:0] dv;
    logic [RATIO_W-1:0] dr;
    pl = r.pend;
    go = 1'b0;
    dv = r.tgt_vid;
    dr = r.tgt_ratio;
    n = r;
    n.ack_cycle = 1'b0;
    n.core_init = 1'b0;
    n.svc = '0;
    n.th_irq = 1'b0;
    n.rdata = '0;
    n.stop_m = !stop_clock_req_n_i; // [RULE26]
    n.stop_s = r.stop_m;
    n.slp_m = !sleep_req_n_i;
    n.slp_s = r.slp_m;
    n.dps_m = !deep_sleep_req_n_i;
    n.dps_s = r.dps_m;
    // events are only held while stop-granting or in snoop service; sleep states drop them
    if (r.st == LP_ACK_WAIT || r.st == LP_GRANT_CNT || r.st == LP_STOP_GRANT || r.st == LP_SNOOP) // [RULE15]
    begin
      pl = r.pend | ev; // [RULE9]
    end
    n.pend = pl;
    case (r.st)
      LP_NORMAL:
      begin
        if (core_rst)
          n.core_init = 1'b1;
        else if (r.stop_s)
        begin
          n.st = LP_ACK_WAIT; // [RULE3]
          n.ack_cycle = 1'b1;
        end
        else if (halt_exec_i)
        begin
          n.st = LP_IDLE; // [RULE1]
          n.halted = 1'b1;
        end
      end
      LP_IDLE:
      begin
        if (core_rst)
        begin
          n.st = LP_NORMAL; // [RULE6]
          n.halted = 1'b0;
          n.core_init = 1'b1;
        end
        else if (ev != '0)
        begin
          n.st = LP_NORMAL; // [RULE1]
          n.halted = 1'b0;
          n.svc = ev;
        end
        else if (r.stop_s)
        begin
          n.st = LP_ACK_WAIT;
          n.ack_cycle = 1'b1;
        end
        else if (snoop_req_i)
        begin
          n.st = LP_SNOOP; // [RULE8]
          n.snoop_ret_idle = 1'b1;
          n.snoop_irq = 1'b0;
        end
      end
      LP_ACK_WAIT, LP_GRANT_CNT, LP_STOP_GRANT:
      begin
        if (core_rst && r.st == LP_STOP_GRANT)
        begin
          n.core_init = 1'b1; // [RULE5]
          n.pend = '0;
          n.halted = 1'b0;
        end
        else if (!r.stop_s)
        begin
          // halted core resumes halted unless events are pending; pending events go out on return to Normal
          n.st = go_idle(r, pl) ? LP_IDLE : LP_NORMAL; // [RULE2] [RULE5]
          n.halted = go_idle(r, pl);
          n.svc = pl; // [RULE9]
          n.pend = '0;
        end
        else if (r.st == LP_ACK_WAIT)
        begin
          n.core_init = core_rst;
          if (ack_resp_done_i)
          begin
            n.st = LP_GRANT_CNT;
            n.cnt = '0;
          end
        end
        else if (r.st == LP_GRANT_CNT)
        begin
          n.core_init = core_rst;
          if (r.cnt == TMR_W'(GRANT_CLKS - 2))
            n.st = LP_STOP_GRANT; // [RULE3]
          else
            n.cnt = r.cnt + 1'b1;
        end
        else if (r.slp_s)
          n.st = LP_SLEEP; // [RULE12]
        else if (snoop_req_i || bus_irq_msg_i)
        begin
          n.st = LP_SNOOP; // [RULE8]
          n.snoop_ret_idle = 1'b0;
          n.snoop_irq = bus_irq_msg_i;
        end
      end
      LP_SNOOP:
      begin
        if (snoop_done_i || r.snoop_irq)
        begin
          if (!r.snoop_ret_idle)
            n.st = LP_STOP_GRANT; // [RULE8]
          else if (pl != '0)
          begin
            n.st = LP_NORMAL;
            n.halted = 1'b0;
            n.svc = pl;
            n.pend = '0;
          end
          else
            n.st = LP_IDLE;
        end
      end
      LP_SLEEP, LP_DEEP, LP_DEEPER, LP_RELOCK:
      begin
        if (core_rst)
        begin
          // reset straight out of sleep, no stop-grant pass
          n.st = LP_NORMAL; // [RULE16]
          n.halted = 1'b0;
          n.pend = '0;
          n.core_init = 1'b1;
        end
        else if (r.st == LP_SLEEP)
        begin
          if (r.dps_s)
            n.st = LP_DEEP; // [RULE17]
          else if (!r.slp_s)
            n.st = LP_STOP_GRANT; // [RULE17]
        end
        else if (r.st == LP_RELOCK)
        begin
          if (r.dps_s)
            n.st = LP_DEEP;
          else if (r.cnt == TMR_W'(RELOCK_CYC - 1))
            n.st = LP_SLEEP; // [RULE19]
          else
            n.cnt = r.cnt + 1'b1;
        end
        else if (!r.dps_s)
        begin
          n.st = LP_RELOCK; // [RULE19]
          n.cnt = '0;
        end
        else
          n.st = deeper_volt_i ? LP_DEEPER : LP_DEEP;
      end
      default:
        n.st = LP_NORMAL;
    endcase
    // interrupt-enable mask deliberately not consulted here
    n.pbe_n = !((n.st == LP_STOP_GRANT || n.st == LP_SNOOP) && n.pend != '0); // [RULE10]
    n.psi_n = !(n.st == LP_DEEP || n.st == LP_DEEPER); // [RULE25]

    // operating-point sequencer
    case (r.op)
      OP_IDLE:
      begin
        if (r.th_waiting)
        begin
          if (r.th_cnt != '0)
            n.th_cnt = r.th_cnt - 1'b1;
          else if (thermal_hot_i)
            n.th_cnt = THW_W'(THERM_WAIT - 1);
          else
          begin
            go = 1'b1; // [RULE23]
            dv = r.prev_vid;
            dr = r.prev_ratio;
            n.throttled = 1'b0;
            n.th_waiting = 1'b0;
            n.th_irq = 1'b1; // [RULE24]
          end
        end
        else if (thermal_hot_i && !r.throttled)
        begin
          go = 1'b1; // [RULE23]
          dv = r.th_vid;
          dr = r.th_ratio;
          n.prev_vid = r.cur_vid;
          n.prev_ratio = r.cur_ratio;
          n.throttled = 1'b1;
          n.th_irq = 1'b1; // [RULE24]
        end
        else if (r.sw_pend && !r.throttled)
        begin
          go = 1'b1; // [RULE21]
          n.sw_pend = 1'b0;
        end
        if (go)
        begin
          n.op = OP_LOCK;
          n.op_up = dr > r.cur_ratio;
          n.mv_vid = dv;
          n.mv_ratio = dr;
          n.op_cnt = TMR_W'(OP_LOCK_CYC - 1);
          if (dr > r.cur_ratio)
            n.cur_vid = dv; // [RULE20]
        end
      end
      OP_LOCK:
      begin
        if (r.op_cnt == '0)
        begin
          n.cur_ratio = r.mv_ratio;
          n.op = OP_FINISH;
        end
        else
          n.op_cnt = r.op_cnt - 1'b1;
      end
      OP_FINISH:
      begin
        if (!r.op_up)
          n.cur_vid = r.mv_vid; // [RULE20]
        n.op = OP_IDLE;
        if (r.throttled)
        begin
          n.th_waiting = 1'b1;
          n.th_cnt = THW_W'(THERM_WAIT - 1);
        end
      end
      default:
        n.op = OP_IDLE;
    endcase
    n.bnr_n = (n.op != OP_LOCK); // [RULE22]

    // a write after a start re-arms the request, so it is never lost
    if (reg_wr_i && reg_addr_i == REG_OP_TARGET)
    begin
      n.tgt_vid = reg_wdata_i[F_VID_LSB +: VID_W];
      n.tgt_ratio = reg_wdata_i[F_RATIO_LSB +: RATIO_W];
      n.sw_pend = 1'b1; // [RULE21]
    end
    if (reg_wr_i && reg_addr_i == REG_THERM_POINT)
    begin
      n.th_vid = reg_wdata_i[F_VID_LSB +: VID_W];
      n.th_ratio = reg_wdata_i[F_RATIO_LSB +: RATIO_W];
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_OP_TARGET:
        begin
          n.rdata[F_VID_LSB +: VID_W] = r.tgt_vid;
          n.rdata[F_RATIO_LSB +: RATIO_W] = r.tgt_ratio;
        end
        REG_THERM_POINT:
        begin
          n.rdata[F_VID_LSB +: VID_W] = r.th_vid;
          n.rdata[F_RATIO_LSB +: RATIO_W] = r.th_ratio;
        end
        REG_STATUS:
        begin
          n.rdata[ST_STATE_LSB +: 4] = r.st;
          n.rdata[ST_BUSY] = (r.op != OP_IDLE) || r.sw_pend;
          n.rdata[ST_THROT] = r.throttled;
          n.rdata[ST_PBE] = !r.pbe_n;
          n.rdata[ST_VID_LSB +: VID_W] = r.cur_vid;
          n.rdata[ST_RATIO_LSB +: RATIO_W] = r.cur_ratio;
        end
        default:
          n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r <= '0;
      r.pbe_n <= 1'b1;
      r.psi_n <= 1'b1;
      r.bnr_n <= 1'b1;
      r.cur_vid <= RST_VID;
      r.cur_ratio <= RST_RATIO;
      r.tgt_vid <= RST_VID;
      r.tgt_ratio <= RST_RATIO;
    end
    else
      r <= n;
  end

  assign reg_rdata_o = r.rdata;
  assign ack_cycle_o = r.ack_cycle;
  assign core_init_o = r.core_init;
  assign evt_service_o = r.svc;
  assign pending_break_n_o = r.pbe_n;
  assign power_status_n_o = r.psi_n;
  assign bus_not_ready_n_o = r.bnr_n;
  assign voltage_id_code_o = r.cur_vid;
  assign core_ratio_o = r.cur_ratio;
  assign thermal_irq_o = r.th_irq;
  assign lp_state_o = r.st; // [RULE27]

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_idle_wake: assert property (r.st == LP_IDLE && !core_rst && ev != '0 |=> // [RULE1]
    r.st == LP_NORMAL && r.svc == $past(ev)) else $error("idle did not wake");
  a_idle_resume: assert property (r.st == LP_STOP_GRANT && !r.stop_s && !core_rst && r.halted && // [RULE2]
    r.pend == '0 && ev == '0 |=> r.st == LP_IDLE) else $error("halted core not resumed idle");
  a_grant_delay: assert property (r.st == LP_STOP_GRANT && $past(r.st) == LP_GRANT_CNT |-> // [RULE3]
    $past(r.cnt) == TMR_W'(GRANT_CLKS - 2)) else $error("stop-grant entry delay wrong");
  a_reset_grant: assert property (r.st == LP_STOP_GRANT && core_rst |=> // [RULE5]
    r.core_init && r.st == LP_STOP_GRANT) else $error("reset left stop-grant");
  a_reset_idle: assert property (r.st == LP_IDLE && core_rst |=> // [RULE6]
    r.core_init && r.st == LP_NORMAL) else $error("idle reset not immediate");
  a_snoop_return: assert property (r.st == LP_SNOOP && snoop_done_i && !r.snoop_ret_idle |=> // [RULE8]
    r.st == LP_STOP_GRANT) else $error("snoop did not return");
  a_pbe_level: assert property (r.st == LP_STOP_GRANT |-> // [RULE10]
    r.pbe_n == (r.pend == '0)) else $error("pending-break wrong");
  a_sleep_source: assert property (r.st == LP_SLEEP && $past(r.st) != LP_SLEEP |-> // [RULE12]
    $past(r.st) inside {LP_STOP_GRANT, LP_RELOCK}) else $error("sleep from bad state");
  a_sleep_nolatch: assert property (r.st inside {LP_SLEEP, LP_DEEP, LP_DEEPER} |=> // [RULE15]
    r.pend == $past(r.pend) || r.pend == '0) else $error("irq latched in sleep");
  a_sleep_reset: assert property (r.st inside {LP_SLEEP, LP_DEEP, LP_DEEPER, LP_RELOCK} && core_rst |=> // [RULE16]
    r.st == LP_NORMAL && r.core_init) else $error("sleep reset not direct");
  a_relock_wait: assert property (r.st == LP_SLEEP && $past(r.st) == LP_RELOCK |-> // [RULE19]
    $past(r.cnt) == TMR_W'(RELOCK_CYC - 1)) else $error("relock too short");
  a_vid_first: assert property (r.op == OP_LOCK && r.op_up |-> // [RULE20] [RULE22]
    r.cur_vid == r.mv_vid && !r.bnr_n) else $error("voltage not raised first");
  a_therm_irq: assert property (r.op == OP_IDLE && !r.th_waiting && thermal_hot_i && !r.throttled |=> // [RULE24]
    r.th_irq && r.throttled ##1 !r.th_irq) else $error("thermal irq missing");
  a_psi_deep: assert property (r.psi_n == !(r.st inside {LP_DEEP, LP_DEEPER})) // [RULE25]
    else $error("power status wrong");
endmodule : cplps_ctrl
`default_nettype wire

// [design/cplps_pkg.sv]
// package: constants and types for the cpu low-power state controller
package cplps_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // stop-grant entry delay after the acknowledge response phase, in bus clocks
  localparam int GRANT_CLKS = 20;
  // loop relock after deep-sleep exit; least time, rounded up
  localparam int RELOCK_US = 30;
  localparam int RELOCK_CYC = (RELOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // core unavailable while the loop relocks; longest time, rounded down
  localparam int OP_LOCK_US = 10;
  localparam int OP_LOCK_CYC = (OP_LOCK_US * 1000) / CLK_PERIOD_NS;
  localparam int THERM_WAIT_US = 1000;
  localparam int THERM_WAIT_CYC = (THERM_WAIT_US * 1000) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam int THW_W = 24;
  localparam int VID_W = 6;
  localparam int RATIO_W = 6;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_OP_TARGET = 4'h0;
  localparam logic [ADDR_W-1:0] REG_THERM_POINT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam int F_VID_LSB = 0;
  localparam int F_RATIO_LSB = 8;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_BUSY = 4;
  localparam int ST_THROT = 5;
  localparam int ST_PBE = 6;
  localparam int ST_VID_LSB = 8;
  localparam int ST_RATIO_LSB = 16;
  localparam logic [VID_W-1:0] RST_VID = 6'h20;
  localparam logic [RATIO_W-1:0] RST_RATIO = 6'h06;
  localparam int EVT_SMI = 0;
  localparam int EVT_INIT = 1;
  localparam int EVT_LINT0 = 2;
  localparam int EVT_LINT1 = 3;
  localparam int EVT_BUS = 4;
  localparam int EVT_W = 5;
  typedef enum logic [3:0] {
    LP_NORMAL, LP_IDLE, LP_ACK_WAIT, LP_GRANT_CNT, LP_STOP_GRANT,
    LP_SNOOP, LP_SLEEP, LP_DEEP, LP_DEEPER, LP_RELOCK
  } cplps_lp_t;
  typedef enum logic [1:0] {OP_IDLE, OP_LOCK, OP_FINISH} cplps_op_t;
endpackage : cplps_pkg

// [testbench/cplps_chipset.sv]
// chipset model: drives the low-power request pins and answers acknowledge cycles
`timescale 1ns/10ps
`default_nettype none
module cplps_chipset (
  input wire logic clk_i, // bus clock
  input wire logic resetn_i, // async reset, active low
  input wire logic ack_cycle_i, // acknowledge cycle issued
  input wire logic stop_i, // bench wants stop-clock
  input wire logic sleep_i, // bench wants sleep
  input wire logic deep_i, // bench wants deep sleep
  input wire logic [3:0] dly_i, // response phase delay
  output logic stop_clock_req_n_o, // stop-clock pin
  output logic sleep_req_n_o, // sleep pin
  output logic deep_sleep_req_n_o, // deep-sleep pin
  output logic ack_resp_done_o // response phase complete
);
  logic [3:0] cnt;
  logic [3:0] gap;
  logic pend;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      {cnt, gap, pend, ack_resp_done_o} <= '0;
      {stop_clock_req_n_o, sleep_req_n_o, deep_sleep_req_n_o} <= 3'h7;
    end
    else
    begin
      ack_resp_done_o <= pend && cnt == 4'h0;
      if (ack_cycle_i)
      begin
        pend <= 1'b1;
        cnt <= dly_i;
      end
      else if (pend)
      begin
        pend <= cnt != 4'h0;
        cnt <= cnt - 4'h1;
      end
      // sleep only on top of stop-clock, and held while deep sleep is asked
      sleep_req_n_o <= !((sleep_i && !stop_clock_req_n_o) || !deep_sleep_req_n_o);
      deep_sleep_req_n_o <= !(deep_i && !sleep_req_n_o);
      gap <= !sleep_req_n_o ? 4'h0 : (gap == 4'hf ? gap : gap + 4'h1);
      if (stop_i)
        stop_clock_req_n_o <= 1'b0;
      else if (gap >= 4'ha)
        stop_clock_req_n_o <= 1'b1;
    end
  end
endmodule : cplps_chipset
`default_nettype wire

// [testbench/cplps_ctrl_tb.sv]
// self-checking bench for the cpu low-power state controller
`timescale 1ns/10ps
`default_nettype none
module cplps_ctrl_tb;
  import cplps_pkg::*;
  logic sys_clk_i, resetn_i, cpu_reset_n_i, deeper_volt_i, halt_exec_i, sys_mgmt_irq_n_i, init_req_n_i;
  logic bus_irq_msg_i, snoop_req_i, snoop_done_i, thermal_hot_i, reg_wr_i, reg_rd_i, ack_cycle_o, core_init_o;
  logic pending_break_n_o, power_status_n_o, bus_not_ready_n_o, thermal_irq_o, w_stop, w_slp, w_deep;
  logic stop_clock_req_n_i, sleep_req_n_i, deep_sleep_req_n_i, ack_resp_done_i;
  logic [1:0] local_irq_lines_i;
  logic [3:0] reg_addr_i, lp_state_o, dly;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [4:0] evt_service_o;
  logic [5:0] voltage_id_code_o, core_ratio_o, v1, r1, v2, r2;
  int errors, compares, k;
  // short relax time so the thermal return is reached quickly
  cplps_ctrl #(.THERM_WAIT(20)) dut (.sys_clk_i, .resetn_i, .cpu_reset_n_i, .stop_clock_req_n_i,
    .sleep_req_n_i, .deep_sleep_req_n_i, .deeper_volt_i, .halt_exec_i, .sys_mgmt_irq_n_i, .init_req_n_i,
    .local_irq_lines_i, .bus_irq_msg_i, .snoop_req_i, .snoop_done_i, .ack_resp_done_i, .thermal_hot_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ack_cycle_o, .core_init_o, .evt_service_o,
    .pending_break_n_o, .power_status_n_o, .bus_not_ready_n_o, .voltage_id_code_o, .core_ratio_o,
    .thermal_irq_o, .lp_state_o);
  cplps_chipset chip (.clk_i(sys_clk_i), .resetn_i, .ack_cycle_i(ack_cycle_o), .stop_i(w_stop),
    .sleep_i(w_slp), .deep_i(w_deep), .dly_i(dly), .stop_clock_req_n_o(stop_clock_req_n_i),
    .sleep_req_n_o(sleep_req_n_i), .deep_sleep_req_n_o(deep_sleep_req_n_i), .ack_resp_done_o(ack_resp_done_i));
  function automatic logic [31:0] exp_st(input logic [5:0] v, input logic [5:0] r);
    return (32'(r) << ST_RATIO_LSB) | (32'(v) << ST_VID_LSB);
  endfunction : exp_st
  function automatic logic [31:0] sig(input int w);
    case (w)
      0: return 32'(lp_state_o);
      1: return 32'(ack_cycle_o);
      2: return 32'(pending_break_n_o);
      3: return 32'(power_status_n_o);
      4: return 32'(bus_not_ready_n_o);
      5: return 32'(voltage_id_code_o);
      6: return 32'(core_ratio_o);
      7: return 32'(thermal_irq_o);
      8: return 32'(evt_service_o);
      default: return 32'(ack_resp_done_i);
    endcase
  endfunction : sig
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // bounded wait for a watched output; k returns the clocks spent
  task automatic upto(input string n, input int w, input logic [31:0] v, input int lim, output int c);
    for (c = 1; c <= lim; c++)
    begin
      @(posedge sys_clk_i);
      #1;
      if (sig(w) === v)
        break;
    end
    chk(n, v, sig(w));
  endtask : upto
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    #1;
  endtask : bus
  task automatic report_and_stop();
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    errors++;
    report_and_stop();
  end
  initial
  begin
    {resetn_i, deeper_volt_i, halt_exec_i, bus_irq_msg_i, snoop_req_i, snoop_done_i, thermal_hot_i} = '0;
    {reg_wr_i, reg_rd_i, local_irq_lines_i, reg_addr_i, reg_wdata_i, w_stop, w_slp, w_deep, dly} = '0;
    {cpu_reset_n_i, sys_mgmt_irq_n_i, init_req_n_i} = 3'h7;
    k = $urandom(32'h7262ee01);
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    bus(0, 0, 0, 0);
    chk("reset outs", {4'h0, 3'h7, RST_VID, RST_RATIO}, {lp_state_o, pending_break_n_o, power_status_n_o,
      bus_not_ready_n_o, voltage_id_code_o, core_ratio_o});
    halt_exec_i <= 1'b1;
    bus(0, 0, 0, 0);
    halt_exec_i <= 1'b0;
    upto("idle", 0, 1, 4, k);
    snoop_req_i <= 1'b1;
    bus(0, 0, 0, 0);
    snoop_req_i <= 1'b0;
    upto("snoop", 0, 5, 4, k);
    snoop_done_i <= 1'b1;
    bus(0, 0, 0, 0);
    snoop_done_i <= 1'b0;
    upto("snoop back", 0, 1, 4, k);
    dly <= 4'($urandom % 8);
    w_stop <= 1'b1;
    upto("ack", 1, 1, 8, k);
    upto("resp", 9, 1, 12, k);
    upto("grant", 0, 4, 30, k);
    chk("grant delay", 20, k);
    w_stop <= 1'b0;
    upto("halt resume", 0, 1, 20, k);
    cpu_reset_n_i <= 1'b0;
    bus(0, 0, 0, 0);
    cpu_reset_n_i <= 1'b1;
    chk("idle reset", 32'h1, {lp_state_o, core_init_o});
    halt_exec_i <= 1'b1;
    bus(0, 0, 0, 0);
    halt_exec_i <= 1'b0;
    local_irq_lines_i <= 2'h1;
    upto("wake", 0, 0, 5, k);
    local_irq_lines_i <= 2'h0;
    w_stop <= 1'b1;
    upto("grant", 0, 4, 60, k);
    cpu_reset_n_i <= 1'b0;
    bus(0, 0, 0, 0);
    cpu_reset_n_i <= 1'b1;
    chk("init", 1, 32'(core_init_o));
    chk("stay grant", 4, lp_state_o);
    local_irq_lines_i <= 2'h2;
    bus(0, 0, 0, 0);
    local_irq_lines_i <= 2'h0;
    upto("pbe", 2, 0, 4, k);
    w_stop <= 1'b0;
    upto("service", 8, 32'(1) << EVT_LINT1, 20, k);
    upto("normal", 0, 0, 3, k);
    w_stop <= 1'b1;
    upto("grant", 0, 4, 60, k);
    w_slp <= 1'b1;
    upto("sleep", 0, 6, 8, k);
    w_deep <= 1'b1;
    upto("deep", 0, 7, 8, k);
    upto("psi on", 3, 0, 3, k);
    deeper_volt_i <= 1'b1;
    upto("deeper", 0, 8, 3, k);
    chk("psi deeper", 0, power_status_n_o);
    deeper_volt_i <= 1'b0;
    w_deep <= 1'b0;
    upto("relock", 0, 9, 8, k);
    upto("relocked", 0, 6, 4000, k);
    chk("relock time", RELOCK_CYC, k);
    chk("psi off", 1, power_status_n_o);
    w_slp <= 1'b0;
    w_stop <= 1'b0;
    upto("back grant", 0, 4, 8, k);
    upto("normal", 0, 0, 30, k);
    r1 = 6'(7 + $urandom % 50);
    v1 = 6'($urandom % 32);
    r2 = r1 - 6'(1 + $urandom % 5);
    v2 = 6'h20 | 6'($urandom % 32);
    bus(1, 0, REG_OP_TARGET, (32'(r1) << F_RATIO_LSB) | 32'(v1));
    bus(1, 0, REG_OP_TARGET, (32'(r2) << F_RATIO_LSB) | 32'(v2));
    bus(0, 0, 0, 0);
    upto("up vid", 5, 32'(v1), 4, k);
    chk("up ratio held", 32'(RST_RATIO), 32'(core_ratio_o));
    upto("bnr", 4, 0, 4, k);
    upto("bnr end", 4, 1, 1300, k);
    chk("bnr time", OP_LOCK_CYC, k + 3);
    upto("up ratio", 6, 32'(r1), 4, k);
    upto("down ratio", 6, 32'(r2), 1400, k);
    chk("down vid held", 32'(v1), 32'(voltage_id_code_o));
    upto("down vid", 5, 32'(v2), 3, k);
    bus(0, 0, 0, 0);
    bus(0, 1, REG_STATUS, 0);
    chk("status", exp_st(v2, r2), reg_rdata_o);
    bus(0, 1, 4'hc, 0);
    chk("unmapped", 0, reg_rdata_o);
    bus(1, 0, REG_THERM_POINT, 32'h0000013f);
    bus(0, 0, 0, 0);
    thermal_hot_i <= 1'b1;
    upto("hot irq", 7, 1, 6, k);
    upto("throttled", 6, 1, 1400, k);
    thermal_hot_i <= 1'b0;
    upto("cool irq", 7, 1, 100, k);
    upto("restored", 6, 32'(r2), 1400, k);
    w_stop <= 1'b1;
    upto("grant", 0, 4, 60, k);
    w_slp <= 1'b1;
    upto("sleep", 0, 6, 8, k);
    cpu_reset_n_i <= 1'b0;
    w_slp <= 1'b0;
    w_stop <= 1'b0;
    bus(0, 0, 0, 0);
    cpu_reset_n_i <= 1'b1;
    chk("sleep reset", 32'h1, {lp_state_o, core_init_o});
    report_and_stop();
  end
endmodule : cplps_ctrl_tb
`default_nettype wire
